//--- smwrc_defines.svh
// constants for the mac width and rate configuration block
`ifndef SMWRC_DEFINES_SVH
`define SMWRC_DEFINES_SVH
`define SMWRC_ADDR_CTRL      4'h0
`define SMWRC_ADDR_WIDTH     4'h4
`define SMWRC_ADDR_STATUS    4'h8
`define SMWRC_CTRL_PD_PRI    0
`define SMWRC_CTRL_PD_SEC    1
`define SMWRC_CTRL_ARR       2
`define SMWRC_CTRL_RATE_LO   4
`define SMWRC_CTRL_RATE_HI   5
`define SMWRC_WID_OVR_LO     0
`define SMWRC_WID_OVR_HI     1
`define SMWRC_WID_REINIT     4
`define SMWRC_STRAP_CYCLES   4'ha
`define SMWRC_TRAIN_CYCLES   8'h40
`define SMWRC_RATE_ILLEGAL   2'h3
`define SMWRC_RESP_OKAY      2'h0
`define SMWRC_RESP_SLVERR    2'h2
`endif

//--- smwrc_link.sv
// one port's link initialisation sequencer
`timescale 1ns/1ns
`include "smwrc_defines.svh"
module smwrc_link
  import smwrc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic hold,
  input  wire logic restart,
  input  wire logic aligned,
  output logic      up
);
  smwrc_link_t state;
  logic [7:0]  count;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= smwrc_s_down;
      count <= 8'h00;
    end else if (hold || restart) begin
      state <= smwrc_s_down;
      count <= 8'h00;
    end else begin
      unique case (state)
        smwrc_s_down: begin
          state <= smwrc_s_train;
        end
        smwrc_s_train: begin
          if (!aligned) begin
            count <= 8'h00;
          end else if (count == `SMWRC_TRAIN_CYCLES) begin
            state <= smwrc_s_up;
          end else begin
            count <= count + 8'h01;
          end
        end
        smwrc_s_up: begin
          if (!aligned) begin
            state <= smwrc_s_train;
          end
        end
        default: state <= smwrc_s_down;
      endcase
    end
  end
  assign up = (state == smwrc_s_up);
endmodule : smwrc_link

//--- smwrc_partner.sv
// link partner model that aligns its lanes once the local link leaves reset
`timescale 1ns/1ns
module smwrc_partner (
  input  wire logic       clock,
  input  wire logic       tx_clock_enable,
  input  wire logic       even_link_reset_n,
  input  wire logic       odd_link_reset_n,
  input  wire logic [3:0] lane_mask,
  input  wire logic [3:0] lock_delay,
  output logic      [3:0] lane_aligned
);
  logic [3:0] wait_cnt;
  // lock only onto a running local transmitter
  always @(posedge clock) begin
    if (!tx_clock_enable || !(even_link_reset_n || odd_link_reset_n)) begin
      wait_cnt     <= lock_delay;
      lane_aligned <= 4'h0;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else begin
      lane_aligned <= lane_mask;
    end
  end
endmodule : smwrc_partner

//--- smwrc_pkg.sv
// types for the mac width and rate configuration block
package smwrc_pkg;
  typedef enum logic [1:0] {
    smwrc_w_auto  = 2'b00,
    smwrc_w_lanea = 2'b10,
    smwrc_w_lanec = 2'b11,
    smwrc_w_rsvd  = 2'b01
  } smwrc_ovr_t;
  typedef enum logic [1:0] {
    smwrc_iw_1a = 2'b00,
    smwrc_iw_1c = 2'b01,
    smwrc_iw_4  = 2'b10,
    smwrc_iw_na = 2'b11
  } smwrc_iw_t;
  typedef enum logic [1:0] {
    smwrc_s_down  = 2'b00,
    smwrc_s_train = 2'b01,
    smwrc_s_up    = 2'b10
  } smwrc_link_t;
endpackage : smwrc_pkg

//--- smwrc_sync.sv
// two flip-flop reset release
`timescale 1ns/1ns
module smwrc_sync (
  input  wire logic clock,
  input  wire logic reset_n,
  output logic      sync_reset_n
);
  logic stage;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage        <= 1'b0;
      sync_reset_n <= 1'b0;
    end else begin
      stage        <= 1'b1;
      sync_reset_n <= stage;
    end
  end
endmodule : smwrc_sync

//--- smwrc_top.sv
// per-mac width, arrangement and line-rate configuration with axi4-lite registers
`timescale 1ns/1ns
`include "smwrc_defines.svh"
module smwrc_top
  import smwrc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [1:0]  default_rate_strap,
  input  wire logic        width_arrangement_strap,
  input  wire logic        port_powerdown_strap,
  input  wire logic        boot_load_active,
  input  wire logic [3:0]  lane_aligned,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [1:0]       tx_rate,
  output logic             tx_clock_enable,
  output logic             arrangement_select,
  output logic             even_lane_a,
  output logic             even_lane_c,
  output logic             odd_lane_b,
  output logic             four_lane_active,
  output logic             even_link_reset_n,
  output logic             odd_link_reset_n,
  output logic             even_link_up,
  output logic             odd_link_up
);
  logic        rst_n;
  logic        pd_pri;
  logic        pd_sec;
  logic        arr;
  logic [1:0]  rate_reg;
  logic [1:0]  rate_live;
  logic [1:0]  width_override;
  logic        forced_reinitialise;
  logic        strap_done;
  logic [3:0]  strap_count;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        even_up;
  logic        odd_up;
  logic        degraded;
  smwrc_iw_t   initialised_width;

  smwrc_sync u_sync (
    .clock        (clock),
    .reset_n      (reset_n),
    .sync_reset_n (rst_n)
  );

  // strap capture: count 10 cycles after release, sample at the end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_count <= 4'h0;
      strap_done  <= 1'b0;
    end else if (!strap_done) begin
      strap_count <= strap_count + 4'h1;
      strap_done  <= (strap_count == `SMWRC_STRAP_CYCLES - 4'h1);
    end
  end
  wire strap_sample = !strap_done && (strap_count == `SMWRC_STRAP_CYCLES - 4'h1);

  // axi write side
  wire do_write  = aw_held && w_held && !bvalid;
  wire wr_ctrl   = do_write && (aw_addr == `SMWRC_ADDR_CTRL);
  wire wr_width  = do_write && (aw_addr == `SMWRC_ADDR_WIDTH);
  wire wr_status = do_write && (aw_addr == `SMWRC_ADDR_STATUS);
  wire wr_ok     = wr_ctrl || wr_width || wr_status;
  wire ctrl_lane = w_strb[0];
  wire new_pd_pri = ctrl_lane ? w_data[`SMWRC_CTRL_PD_PRI] : pd_pri;
  wire new_pd_sec = ctrl_lane ? w_data[`SMWRC_CTRL_PD_SEC] : pd_sec;
  // arrangement changes only while both groups already down
  wire arr_allowed = pd_pri && pd_sec;
  // a degraded four-lane port cannot be split into two single-lane ports
  wire arr_block_split = degraded && !arr;
  wire [1:0] wr_rate = w_data[`SMWRC_CTRL_RATE_HI:`SMWRC_CTRL_RATE_LO];
  wire rate_legal = (wr_rate != `SMWRC_RATE_ILLEGAL);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `SMWRC_RESP_OKAY;
    end else begin
      awready <= !aw_held && !awready;
      wready  <= !w_held && !wready;
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? `SMWRC_RESP_OKAY : `SMWRC_RESP_SLVERR;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control register: power-down, arrangement, rate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_pri   <= 1'b0;
      pd_sec   <= 1'b1;
      arr      <= 1'b0;
      rate_reg <= 2'h0;
    end else if (strap_sample) begin
      arr      <= width_arrangement_strap;
      pd_sec   <= port_powerdown_strap;
      rate_reg <= default_rate_strap;
    end else if (wr_ctrl) begin
      pd_pri <= new_pd_pri;
      pd_sec <= new_pd_sec;
      if (ctrl_lane && arr_allowed && !(arr_block_split && w_data[`SMWRC_CTRL_ARR])) begin
        arr <= w_data[`SMWRC_CTRL_ARR];
      end
      if (ctrl_lane && rate_legal) begin
        rate_reg <= wr_rate;
      end
    end
  end

  // width override and forced reinitialise (self clearing)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      width_override      <= 2'h0;
      forced_reinitialise <= 1'b0;
    end else if (wr_width && w_strb[0]) begin
      width_override      <= w_data[`SMWRC_WID_OVR_HI:`SMWRC_WID_OVR_LO];
      forced_reinitialise <= w_data[`SMWRC_WID_REINIT];
    end else begin
      forced_reinitialise <= 1'b0;
    end
  end

  // rate taken up at strap sampling and while the primary group is powered down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_live <= 2'h0;
    end else if (pd_pri || strap_sample) begin
      rate_live <= strap_sample ? default_rate_strap : rate_reg;
    end
  end

  // link hold: powered down, strap pending, boot load running, or (odd link only) four-lane arrangement
  wire even_hold = pd_pri || !strap_done || boot_load_active;
  wire odd_hold  = pd_sec || !arr || even_hold;
  wire ovr_a = (width_override == smwrc_w_lanea);
  wire ovr_c = (width_override == smwrc_w_lanec);
  wire all_aligned = &lane_aligned;
  // four-lane negotiation falls back to lane a, then lane c
  wire use4  = !arr && !ovr_a && !ovr_c && all_aligned;
  wire use_a = arr || ovr_a || (!use4 && !ovr_c && lane_aligned[0]);
  wire use_c = !arr && !use4 && !use_a;
  wire even_aligned = use4 ? all_aligned : (use_a ? lane_aligned[0] : lane_aligned[2]);

  smwrc_link u_even (
    .clock   (clock),
    .rst_n   (rst_n),
    .hold    (even_hold),
    .restart (forced_reinitialise),
    .aligned (even_aligned),
    .up      (even_up)
  );

  smwrc_link u_odd (
    .clock   (clock),
    .rst_n   (rst_n),
    .hold    (odd_hold),
    .restart (forced_reinitialise),
    .aligned (lane_aligned[1]),
    .up      (odd_up)
  );

  always_comb begin
    if (!even_up) begin
      initialised_width = smwrc_iw_na;
    end else if (use4) begin
      initialised_width = smwrc_iw_4;
    end else if (use_a) begin
      initialised_width = smwrc_iw_1a;
    end else begin
      initialised_width = smwrc_iw_1c;
    end
  end

  // degraded: configured four-lane but running single-lane
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      degraded <= 1'b0;
    end else if (!even_hold) begin
      // held while powered down, so a split stays refused
      degraded <= !arr && even_up && !use4;
    end
  end

  // axi read side
  wire [31:0] rd_ctrl   = {26'h0, rate_reg, 1'b0, arr, pd_sec, pd_pri};
  wire [31:0] rd_width  = {27'h0, forced_reinitialise, 2'h0, width_override};
  wire [31:0] rd_status = {22'h0, rate_live, lane_aligned, degraded, odd_up, initialised_width};
  wire rd_hit_c = (araddr == `SMWRC_ADDR_CTRL);
  wire rd_hit_w = (araddr == `SMWRC_ADDR_WIDTH);
  wire rd_hit_s = (araddr == `SMWRC_ADDR_STATUS);
  wire [31:0] rd_mux = rd_hit_c ? rd_ctrl : (rd_hit_w ? rd_width : (rd_hit_s ? rd_status : 32'h0));
  wire rd_ok = rd_hit_c || rd_hit_w || rd_hit_s;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `SMWRC_RESP_OKAY;
    end else begin
      arready <= !rvalid && !arready && !arvalid ? 1'b1 : (!rvalid && !arready);
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_mux;
        rresp   <= rd_ok ? `SMWRC_RESP_OKAY : `SMWRC_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // registered outputs; one transmit clock and rate for both ports
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_rate            <= 2'h0;
      tx_clock_enable    <= 1'b0;
      arrangement_select <= 1'b0;
      even_lane_a        <= 1'b0;
      even_lane_c        <= 1'b0;
      odd_lane_b         <= 1'b0;
      four_lane_active   <= 1'b0;
      even_link_reset_n  <= 1'b0;
      odd_link_reset_n   <= 1'b0;
      even_link_up       <= 1'b0;
      odd_link_up        <= 1'b0;
    end else begin
      tx_rate            <= rate_live;
      tx_clock_enable    <= strap_done;
      arrangement_select <= arr;
      even_lane_a        <= !even_hold && use_a;
      even_lane_c        <= !even_hold && use_c;
      odd_lane_b         <= !odd_hold;
      four_lane_active   <= !even_hold && use4;
      even_link_reset_n  <= !even_hold;
      odd_link_reset_n   <= !odd_hold;
      even_link_up       <= even_up;
      odd_link_up        <= odd_up;
    end
  end
endmodule : smwrc_top

//--- smwrc_top_asserts.sv
// concurrent checks on the configuration block ports
`timescale 1ns/1ns
module smwrc_asserts (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        boot_load_active,
  input wire logic        bready,
  input wire logic        rready,
  input wire logic        bvalid,
  input wire logic [1:0]  bresp,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  tx_rate,
  input wire logic        tx_clock_enable,
  input wire logic        four_lane_active,
  input wire logic        even_lane_a,
  input wire logic        even_lane_c,
  input wire logic        odd_lane_b,
  input wire logic        even_link_reset_n,
  input wire logic        even_link_up,
  input wire logic        odd_link_up
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_lane_pair;  odd_lane_b |-> even_lane_a && !four_lane_active; endproperty
  property p_lane_excl;  !(even_lane_a && even_lane_c); endproperty
  property p_rate_legal; tx_clock_enable |-> tx_rate != 2'h3; endproperty
  property p_rate_move;
    $changed(tx_rate) && $past(tx_clock_enable, 2) |-> !$past(even_link_up);
  endproperty
  property p_odd_down;   four_lane_active [*2] |-> !odd_link_up; endproperty
  property p_boot_hold;  boot_load_active [*3] |-> !even_link_up && !odd_link_up; endproperty
  property p_clk_run;    tx_clock_enable |=> tx_clock_enable; endproperty
  property p_train;      $rose(even_link_up) |-> $past(even_link_reset_n, 60); endproperty
  property p_link_rst;   !even_link_reset_n [*2] |-> !even_link_up; endproperty
  property p_b_hold;     bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_r_hold;     rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_lane_pair: assert property (p_lane_pair) else $error("odd lane without even lane a");
  a_lane_excl: assert property (p_lane_excl) else $error("lanes a and c both used");
  a_rate_legal: assert property (p_rate_legal) else $error("illegal live rate");
  a_rate_move: assert property (p_rate_move) else $error("rate moved under live link");
  a_odd_down: assert property (p_odd_down) else $error("odd link up in four-lane");
  a_boot_hold: assert property (p_boot_hold) else $error("link up during boot load");
  a_clk_run: assert property (p_clk_run) else $error("transmit clock stopped");
  a_train: assert property (p_train) else $error("link up without training");
  a_link_rst: assert property (p_link_rst) else $error("link up while in reset");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  c_even_up: cover property ($rose(even_link_up));
  c_odd_up: cover property ($rose(odd_link_up));
  c_slverr: cover property (bvalid && bresp == 2'h2);
  c_rate: cover property ($changed(tx_rate) && tx_clock_enable);
endmodule : smwrc_asserts
bind smwrc_top smwrc_asserts i_smwrc_asserts (.clock, .reset_n, .boot_load_active, .bready,
  .rready, .bvalid, .bresp, .rvalid, .rdata, .tx_rate, .tx_clock_enable, .four_lane_active,
  .even_lane_a, .even_lane_c, .odd_lane_b, .even_link_reset_n, .even_link_up, .odd_link_up);

//--- smwrc_top_tb.sv
// self-checking bench for the width and rate configuration block
`timescale 1ns/1ns
module smwrc_top_tb
  import smwrc_pkg::*;
;
  logic clock, reset_n, width_arrangement_strap, port_powerdown_strap, boot_load_active;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic tx_clock_enable, arrangement_select, even_lane_a, even_lane_c, odd_lane_b;
  logic four_lane_active, even_link_reset_n, odd_link_reset_n, even_link_up, odd_link_up;
  logic [1:0]  default_rate_strap, bresp, rresp, tx_rate, rv, rt, rc;
  logic [3:0]  lane_aligned, awaddr, araddr, wstrb, lane_mask, lock_delay;
  logic [31:0] wdata, rdata, d, seed_val;
  logic [1:0]  ups;
  int          err_total, tests_run;
  assign ups = {odd_link_up, even_link_up};
  smwrc_top i_smwrc_top (.clock, .reset_n, .default_rate_strap, .width_arrangement_strap,
    .port_powerdown_strap, .boot_load_active, .lane_aligned, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .tx_rate, .tx_clock_enable, .arrangement_select,
    .even_lane_a, .even_lane_c, .odd_lane_b, .four_lane_active, .even_link_reset_n,
    .odd_link_reset_n, .even_link_up, .odd_link_up);
  smwrc_partner i_smwrc_partner (.clock, .tx_clock_enable, .even_link_reset_n,
    .odd_link_reset_n, .lane_mask, .lock_delay, .lane_aligned);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clock);
    while (!bvalid && n < 100) begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      @(posedge clock);
    end
    r = bresp;
    bready <= 1'b0;
    chk(n < 100, 1'b1);
    @(posedge clock);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clock);
    while (!rvalid && n < 100) begin
      if (arready) arvalid <= 1'b0;
      n++;
      @(posedge clock);
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    chk(n < 100, 1'b1);
    @(posedge clock);
  endtask : axi_rd
  task automatic wait_up(input int i, input logic v);
    int n;
    n = 0;
    while (ups[i] !== v && n < 400) begin
      n++;
      @(posedge clock);
    end
    chk(ups[i], v);
  endtask : wait_up
  task automatic print_verdict;
    $display("tests %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    print_verdict();
  end
  initial begin
    seed_val = $urandom(32'h5228);
    rt = 2'($urandom % 3);
    {reset_n, awvalid, wvalid, bready, arvalid, rready, boot_load_active} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    default_rate_strap = rt;
    width_arrangement_strap = 1'b0;
    port_powerdown_strap = 1'b1;
    lane_mask = 4'hf;
    lock_delay = 4'h2;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (20) @(posedge clock);
    width_arrangement_strap <= 1'b1;
    chk(tx_rate, rt);
    chk(tx_clock_enable, 1'b1);
    wait_up(0, 1'b1);
    chk(four_lane_active, 1'b1);
    axi_rd(4'h8, d, rv);
    chk(d[1:0], smwrc_iw_4);
    chk(arrangement_select, 1'b0);
    $display("strap test done");
    for (int k = 0; k < 6; k++) begin
      rc = (k < 4) ? k[1:0] : 2'($urandom);
      lock_delay <= 4'($urandom);
      axi_wr(4'h0, {26'h0, rt, 4'h3}, rv);
      repeat (3) @(posedge clock);
      chk(even_link_reset_n, 1'b0);
      axi_wr(4'h0, {26'h0, rc, 4'h3}, rv);
      if (rc != 2'h3) rt = rc;
      axi_wr(4'h0, {26'h0, rc, 4'h2}, rv);
      repeat (3) @(posedge clock);
      chk(tx_rate, rt);
      wait_up(0, 1'b1);
    end
    $display("rate test done");
    for (int k = 0; k < 3; k++) begin
      axi_wr(4'h4, (k == 0) ? 32'h13 : (k == 1) ? 32'h12 : 32'h10, rv);
      wait_up(0, 1'b0);
      wait_up(0, 1'b1);
      axi_rd(4'h8, d, rv);
      chk(d[1:0], (k == 0) ? smwrc_iw_1c : (k == 1) ? smwrc_iw_1a : smwrc_iw_4);
      chk({even_lane_a, even_lane_c}, (k == 0) ? 2'b01 : (k == 1) ? 2'b10 : 2'b00);
    end
    lane_mask <= 4'h1;
    axi_wr(4'h4, 32'h10, rv);
    wait_up(0, 1'b0);
    wait_up(0, 1'b1);
    axi_rd(4'h8, d, rv);
    chk({d[3], d[1:0]}, {1'b1, smwrc_iw_1a});
    axi_wr(4'h0, {26'h0, rt, 4'h3}, rv);
    axi_wr(4'h0, {26'h0, rt, 4'h7}, rv);
    chk(arrangement_select, 1'b0);
    axi_wr(4'h0, {26'h0, rt, 4'h2}, rv);
    wait_up(0, 1'b1);
    lane_mask <= 4'hf;
    axi_wr(4'h4, 32'h10, rv);
    wait_up(0, 1'b0);
    wait_up(0, 1'b1);
    axi_rd(4'h8, d, rv);
    chk(d[1:0], smwrc_iw_4);
    $display("width test done");
    axi_wr(4'h0, {26'h0, rt, 4'h4}, rv);
    chk(arrangement_select, 1'b0);
    axi_wr(4'h0, {26'h0, rt, 4'h3}, rv);
    axi_wr(4'h0, {26'h0, rt, 4'h7}, rv);
    chk(arrangement_select, 1'b1);
    axi_wr(4'h0, {26'h0, rt, 4'h4}, rv);
    wait_up(1, 1'b1);
    chk(odd_link_reset_n, 1'b1);
    chk({even_lane_a, odd_lane_b, four_lane_active}, 3'b110);
    chk(tx_rate, rt);
    boot_load_active <= 1'b1;
    repeat (8) @(posedge clock);
    chk(ups, 2'b00);
    chk(tx_clock_enable, 1'b1);
    boot_load_active <= 1'b0;
    wait_up(1, 1'b1);
    axi_rd(4'hc, d, rv);
    chk({30'h0, rv}, 32'h2);
    chk(d, 32'h0);
    axi_wr(4'hc, 32'h0, rv);
    chk(rv, 2'h2);
    $display("arrangement test done");
    print_verdict();
  end
endmodule : smwrc_top_tb
